// >>> cpr_config_reader.sv
// start-up configuration capture, field decode, readback and enable qualification
// Function
// - stay disabled until rails, enable, timeout
// - disable when any rail or enable falls
// - on/off config picks bus, pin, both; enable pin is required in every setting
// - first code is boot voltage selection
// - second code bit7 selects pulse skipping
// - second code bits 6:5 thermistor compensation
// - second code bits 4:0 bus address
// - third code bit7 ultrasonic light load
// - third code bit6 latch or retry
// - third code bits 5:3 switching frequency
// - third code bits 2:0 amplifier gain
// - fourth code bits 7:5 ramp rate
// - fourth code bits 4:3 ramp resistor
// - fourth bit2 gain multiplier, 1:0 ignored
// - commands dc..df return captured codes
// - zero boot code: drive tri-state, reference zero
// - bus voltage write before enable overrides boot
`include "cpr_map.svh"
`default_nettype none
module cpr_config_reader #(
    parameter int unsigned TIMEOUT_CYCLES = `CPR_TIMEOUT_CYCLES  // start-up timeout in clocks
) (
    input  wire logic             clk,                   // 200 MHz clock
    input  wire logic             reset,                 // async reset, active high
    input  wire logic             input_supply_pin,      // input rail above threshold
    input  wire logic             high_bias_regulator_rail, // high bias rail ok
    input  wire logic             driver_supply_rail,    // driver rail ok
    input  wire logic             logic_supply_ok,       // logic bias rail ok
    input  wire logic             enable_pin,            // enable above threshold
    input  wire cpr_pkg::cpr_code_t boot_voltage_code_pin,  // digitised first code
    input  wire cpr_pkg::cpr_code_t mode_address_code_pin,  // digitised second code
    input  wire cpr_pkg::cpr_code_t fault_frequency_code_pin, // digitised third code
    input  wire cpr_pkg::cpr_code_t ramp_loop_code_pin,  // digitised fourth code
    input  wire logic             code_valid,            // converter codes are valid
    input  wire logic [1:0]       on_off_config,         // on/off source select
    input  wire logic             operation_on,          // bus operation on bit
    input  wire logic             vout_cmd_write,        // successful vout command pulse
    input  wire logic [7:0]       vout_cmd_value,        // written vout code
    input  wire logic             cmd_read,              // bus read strobe
    input  wire logic [7:0]       cmd_code,              // bus command code
    output logic [7:0]            read_data,             // readback byte
    output logic                  read_ack,              // command recognised
    output logic                  device_enabled,        // controller enabled
    output logic                  bus_accessible,        // timeout expired
    output logic [7:0]            boot_voltage_code,     // active boot code
    output logic                  output_off,            // boot code is zero
    output logic                  drive_oe_n,            // power stage drive enable, low drives
    output logic                  pulse_skipping_mode,   // light-load pulse skipping
    output logic [1:0]            thermistor_compensation, // temp comp select
    output logic [4:0]            bus_address_select,    // address index
    output logic                  ultrasonic_light_load_enable, // 25 kHz clamp
    output logic                  fault_retry_mode,      // 1 = retry, 0 = latch
    output logic [2:0]            frequency_select,      // switching frequency
    output logic [2:0]            amp_gain_select,       // error amp gain
    output logic [2:0]            ramp_rate_select,      // soft-start ramp rate
    output logic [1:0]            loop_ramp_resistor_select, // ramp resistor
    output logic                  gain_multiplier_select // 0 = 1x, 1 = 2x
);
    import cpr_pkg::*;

    // ----------------------------------------------------------------
    // rail qualification and sequencing
    // ----------------------------------------------------------------
    localparam int unsigned CW = $clog2(TIMEOUT_CYCLES + 1);

    cpr_state_t      state_reg, state_next;
    logic [CW-1:0]   timer_reg;
    logic            rails_ok;
    logic            on_request;
    logic            captured_reg;
    cpr_code_t       code1_reg, code2_reg, code3_reg, code4_reg;
    cpr_code_t       boot_reg;

    // all four rails together, enable is qualified separately; comparator hysteresis lives in analog
    assign rails_ok = input_supply_pin & high_bias_regulator_rail & driver_supply_rail
                    & logic_supply_ok;

    // on/off source selection
    always_comb begin
        case (on_off_config)
            `CPR_ONOFF_BUS:  on_request = operation_on;
            `CPR_ONOFF_PIN:  on_request = enable_pin;
            `CPR_ONOFF_BOTH: on_request = enable_pin & operation_on;
            default:         on_request = 1'b1;
        endcase
    end

    // state transitions; any rail drop restarts the whole sequence
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            CPR_ST_WAIT_RAILS: if (rails_ok) state_next = CPR_ST_TIMEOUT;
            CPR_ST_TIMEOUT: begin
                if (!rails_ok) begin
                    state_next = CPR_ST_WAIT_RAILS;
                end else if (timer_reg == CW'(TIMEOUT_CYCLES - 1)) begin
                    state_next = CPR_ST_READY;
                end
            end
            CPR_ST_READY: begin
                if (!rails_ok) begin
                    state_next = CPR_ST_WAIT_RAILS;
                end else if (on_request && enable_pin) begin
                    state_next = CPR_ST_ENABLED;
                end
            end
            CPR_ST_ENABLED: begin
                if (!rails_ok || !enable_pin) begin
                    state_next = CPR_ST_WAIT_RAILS;
                end else if (!on_request) begin
                    state_next = CPR_ST_READY;
                end
            end
            default: state_next = CPR_ST_WAIT_RAILS;
        endcase
    end

    // state register
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state_reg <= CPR_ST_WAIT_RAILS;
        end else begin
            state_reg <= state_next;
        end
    end

    // timeout counter runs only while waiting out the start-up delay
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            timer_reg <= '0;
        end else if (state_reg == CPR_ST_TIMEOUT) begin
            timer_reg <= timer_reg + CW'(1);
        end else begin
            timer_reg <= '0;
        end
    end

    // ----------------------------------------------------------------
    // code capture
    // ----------------------------------------------------------------
    // one capture per power-on reset; later pin noise cannot move the setup
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            captured_reg <= 1'b0;
            code1_reg    <= `CPR_CODE_RESET;
            code2_reg    <= `CPR_CODE_RESET;
            code3_reg    <= `CPR_CODE_RESET;
            code4_reg    <= `CPR_CODE_RESET;
        end else if (!captured_reg && code_valid && state_reg == CPR_ST_TIMEOUT) begin
            captured_reg <= 1'b1;
            code1_reg    <= boot_voltage_code_pin;
            code2_reg    <= mode_address_code_pin;
            code3_reg    <= fault_frequency_code_pin;
            code4_reg    <= ramp_loop_code_pin;
        end
    end

    // active boot code: captured value, overridden by a bus write before enable
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            boot_reg <= `CPR_CODE_RESET;
        end else if (vout_cmd_write && state_reg == CPR_ST_READY) begin
            boot_reg <= vout_cmd_value;
        end else if (!captured_reg && code_valid && state_reg == CPR_ST_TIMEOUT) begin
            boot_reg <= boot_voltage_code_pin;
        end
    end

    // ----------------------------------------------------------------
    // field decode outputs
    // ----------------------------------------------------------------
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            pulse_skipping_mode          <= 1'b0;
            thermistor_compensation      <= 2'h0;
            bus_address_select           <= 5'h00;
            ultrasonic_light_load_enable <= 1'b0;
            fault_retry_mode             <= 1'b0;
            frequency_select             <= 3'h0;
            amp_gain_select              <= 3'h0;
            ramp_rate_select             <= 3'h0;
            loop_ramp_resistor_select    <= 2'h0;
            gain_multiplier_select       <= 1'b0;
        end else begin
            pulse_skipping_mode          <= code2_reg[`CPR_PULSE_SKIP_BIT];
            thermistor_compensation      <= code2_reg[`CPR_THERM_HI:`CPR_THERM_LO];
            bus_address_select           <= code2_reg[`CPR_ADDR_HI:`CPR_ADDR_LO];
            ultrasonic_light_load_enable <= code3_reg[`CPR_ULTRA_BIT];
            fault_retry_mode             <= code3_reg[`CPR_FAULT_BIT];
            frequency_select             <= code3_reg[`CPR_FREQ_HI:`CPR_FREQ_LO];
            amp_gain_select              <= code3_reg[`CPR_GAIN_HI:`CPR_GAIN_LO];
            ramp_rate_select             <= code4_reg[`CPR_RATE_HI:`CPR_RATE_LO];
            loop_ramp_resistor_select    <= code4_reg[`CPR_RRES_HI:`CPR_RRES_LO];
            gain_multiplier_select       <= code4_reg[`CPR_MULT_BIT];
        end
    end

    // ----------------------------------------------------------------
    // enable, boot voltage and output-off
    // ----------------------------------------------------------------
    // zero boot code means off: stage stays tri-stated, reference at zero
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            device_enabled    <= 1'b0;
            bus_accessible    <= 1'b0;
            boot_voltage_code <= 8'h00;
            output_off        <= 1'b1;
            drive_oe_n        <= 1'b1;
        end else begin
            device_enabled    <= (state_next == CPR_ST_ENABLED);
            bus_accessible    <= (state_next == CPR_ST_READY) || (state_next == CPR_ST_ENABLED);
            boot_voltage_code <= boot_reg;
            output_off        <= (boot_reg == 8'h00);
            drive_oe_n        <= !((state_next == CPR_ST_ENABLED) && (boot_reg != 8'h00));
        end
    end

    // ----------------------------------------------------------------
    // readback of captured codes
    // ----------------------------------------------------------------
    // codes read back raw; unused low bits of fourth code returned as captured
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            read_data <= 8'h00;
            read_ack  <= 1'b0;
        end else begin
            read_ack  <= 1'b0;
            if (cmd_read) begin
                read_ack <= 1'b1;
                case (cmd_code)
                    `CPR_CMD_BOOT_READBACK:  read_data <= code1_reg;
                    `CPR_CMD_MODE_READBACK:  read_data <= code2_reg;
                    `CPR_CMD_FAULT_READBACK: read_data <= code3_reg;
                    `CPR_CMD_RAMP_READBACK:  read_data <= code4_reg;
                    default: begin
                        read_data <= 8'h00;
                        read_ack  <= 1'b0;
                    end
                endcase
            end
        end
    end
endmodule : cpr_config_reader
`default_nettype wire

// >>> cpr_map.svh
// register offsets, field positions and timing constants of the configuration pin reader
`ifndef CPR_MAP_SVH
`define CPR_MAP_SVH
// readback command codes
`define CPR_CMD_BOOT_READBACK    8'hdc
`define CPR_CMD_MODE_READBACK    8'hdd
`define CPR_CMD_FAULT_READBACK   8'hde
`define CPR_CMD_RAMP_READBACK    8'hdf
// on/off configuration encodings (bus command, pin, or both)
`define CPR_ONOFF_BUS            2'h1
`define CPR_ONOFF_PIN            2'h2
`define CPR_ONOFF_BOTH           2'h3
// field positions of the second code
`define CPR_PULSE_SKIP_BIT       7
`define CPR_THERM_HI             6
`define CPR_THERM_LO             5
`define CPR_ADDR_HI              4
`define CPR_ADDR_LO              0
// field positions of the third code
`define CPR_ULTRA_BIT            7
`define CPR_FAULT_BIT            6
`define CPR_FREQ_HI              5
`define CPR_FREQ_LO              3
`define CPR_GAIN_HI              2
`define CPR_GAIN_LO              0
// field positions of the fourth code
`define CPR_RATE_HI              7
`define CPR_RATE_LO              5
`define CPR_RRES_HI              4
`define CPR_RRES_LO              3
`define CPR_MULT_BIT             2
// reset value of captured codes
`define CPR_CODE_RESET           8'h00
// timing: start-up timeout in microseconds (typical), clock in MHz
`define CPR_TIMEOUT_US           5500
`define CPR_CLK_MHZ              200
`define CPR_TIMEOUT_CYCLES       (`CPR_TIMEOUT_US * `CPR_CLK_MHZ)
`endif

// >>> cpr_pkg.sv
// types shared by the configuration pin reader
`default_nettype none
package cpr_pkg;
    // sequencing states, one-hot
    typedef enum logic [3:0] {
        CPR_ST_WAIT_RAILS = 4'b0001,
        CPR_ST_TIMEOUT    = 4'b0010,
        CPR_ST_READY      = 4'b0100,
        CPR_ST_ENABLED    = 4'b1000
    } cpr_state_t;
    typedef logic [7:0] cpr_code_t;
endpackage : cpr_pkg
`default_nettype wire

// >>> cpr_config_reader_assertions.sv
// port-level checks of the configuration pin reader
`default_nettype none
module cpr_config_reader_assertions #(
    parameter int unsigned TIMEOUT_CYCLES = 20  // start-up timeout in clocks
) (
    input wire logic       clk, reset,  // clock and async reset
    input wire logic       input_supply_pin, high_bias_regulator_rail,  // bias rails
    input wire logic       driver_supply_rail, logic_supply_ok, enable_pin, operation_on,
    input wire logic       cmd_read, read_ack, device_enabled, bus_accessible, vout_cmd_write,
    input wire logic       output_off, drive_oe_n, pulse_skipping_mode, fault_retry_mode,
    input wire logic       ultrasonic_light_load_enable, gain_multiplier_select,
    input wire logic [1:0] on_off_config, thermistor_compensation, loop_ramp_resistor_select,
    input wire logic [2:0] frequency_select, amp_gain_select, ramp_rate_select,
    input wire logic [4:0] bus_address_select,  // address index
    input wire logic [7:0] cmd_code, read_data, boot_voltage_code, vout_cmd_value
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    logic        rails_ok;  // all four bias rails up
    logic [15:0] rail_cnt;  // consecutive cycles with rails up, saturating
    logic        settled;   // timeout seen, fields must hold from now on
    assign rails_ok = input_supply_pin & high_bias_regulator_rail & driver_supply_rail
                    & logic_supply_ok;
    // -------------------------------------------------------------
    // helper counters
    // -------------------------------------------------------------
    always_ff @(posedge clk or posedge reset) begin
        if (reset || !rails_ok) begin
            rail_cnt <= 16'h0000;
        end else if (rail_cnt < 16'hfff0) begin
            rail_cnt <= rail_cnt + 16'h0001;
        end
    end
    // only a reset clears it: a rail drop must not allow a recapture
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            settled <= 1'b0;
        end else if (bus_accessible) begin
            settled <= 1'b1;
        end
    end
    // -------------------------------------------------------------
    // sequences and assertions
    // -------------------------------------------------------------
    sequence s_read(logic [7:0] lo, logic [7:0] hi);
        cmd_read && cmd_code >= lo && cmd_code <= hi;
    endsequence
    sequence s_ready_write;
        vout_cmd_write && bus_accessible && !device_enabled;
    endsequence
    a_read_ack_pulse: assert property (s_read(8'hdc, 8'hdf) |=> read_ack)
        else $error("readback command not acknowledged");
    // read data stands until the next read, so only a refused code must clear it
    a_read_other_refused: assert property ((cmd_read && (cmd_code < 8'hdc || cmd_code > 8'hdf))
        |=> !read_ack && read_data == 8'h00) else $error("unknown command answered");
    a_idle_no_ack: assert property (!cmd_read |=> !read_ack)
        else $error("acknowledge without a read strobe");
    a_mode_readback: assert property (s_read(8'hdd, 8'hdd) ##0 settled |=> read_data ==
        {pulse_skipping_mode, thermistor_compensation, bus_address_select})
        else $error("second code fields disagree with readback");
    a_fault_readback: assert property (s_read(8'hde, 8'hde) ##0 settled |=> read_data ==
        {ultrasonic_light_load_enable, fault_retry_mode, frequency_select, amp_gain_select})
        else $error("third code fields disagree with readback");
    a_ramp_readback: assert property (s_read(8'hdf, 8'hdf) ##0 settled |=> read_data[7:2] ==
        {ramp_rate_select, loop_ramp_resistor_select, gain_multiplier_select})
        else $error("fourth code fields disagree with readback");
    a_timeout_min: assert property ($rose(bus_accessible) |-> rail_cnt > TIMEOUT_CYCLES)
        else $error("bus accessible before start-up timeout");
    a_timeout_max: assert property (rail_cnt == TIMEOUT_CYCLES + 3 |-> bus_accessible)
        else $error("start-up timeout overran");
    a_rail_drop_off: assert property (!rails_ok || !enable_pin |=> !device_enabled)
        else $error("still enabled after rail or enable drop");
    a_bus_onoff: assert property (on_off_config[0] && !operation_on |=> !device_enabled)
        else $error("enabled without bus on request");
    a_off_flag: assert property (output_off == (boot_voltage_code == 8'h00))
        else $error("output off flag disagrees with boot code");
    a_stage_tristate: assert property (output_off || !device_enabled |-> drive_oe_n)
        else $error("power stage driven while off");
    a_vout_override: assert property (s_ready_write |-> ##2 boot_voltage_code ==
        $past(vout_cmd_value, 2)) else $error("vout write did not replace boot code");
    a_fields_hold: assert property (settled |-> $stable({pulse_skipping_mode,
        thermistor_compensation, bus_address_select, ultrasonic_light_load_enable,
        fault_retry_mode, frequency_select, amp_gain_select, ramp_rate_select,
        loop_ramp_resistor_select, gain_multiplier_select}))
        else $error("captured fields changed");
endmodule : cpr_config_reader_assertions
`default_nettype wire

// >>> cpr_divider_model.sv
// divider and converter model presenting the four programming codes
`default_nettype none
module cpr_divider_model #(
    parameter int unsigned SETTLE = 6  // conversion time in clocks after reset
) (
    input  wire logic        clk,       // system clock
    input  wire logic        reset,     // async reset, active high
    input  wire logic [31:0] setting,   // divider settings, first code in top byte
    output logic      [31:0] codes,     // digitised codes, garbage while converting
    output logic             code_valid // conversion finished
);
    logic [3:0] cnt_reg;  // conversion progress
    // the converter restarts with every reset
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            cnt_reg <= 4'h0;
        end else if (cnt_reg != 4'hf) begin
            cnt_reg <= cnt_reg + 4'h1;
        end
    end
    assign code_valid = (cnt_reg >= 4'(SETTLE));
    // alternates inverse and true setting while converting; only code_valid guards an early capture
    assign codes = code_valid ? setting : ~setting ^ {32{cnt_reg[0]}};
endmodule : cpr_divider_model
`default_nettype wire

// >>> testbench.sv
// self-checking bench for the configuration pin reader
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int unsigned TMO = 20;  // shortened start-up timeout
    logic        clk, reset, enable_pin, operation_on, vout_cmd_write, cmd_read, code_valid;
    logic        read_ack, device_enabled, bus_accessible, output_off, drive_oe_n;
    logic        pskip, ultra, retry, mult;
    logic [1:0]  on_off_config, therm, rres;
    logic [2:0]  freq, gain, rate;
    logic [3:0]  rails;  // input, high bias, driver, logic rails
    logic [4:0]  addr;
    logic [7:0]  vout_cmd_value, cmd_code, read_data, boot_code, v2;
    logic [31:0] setting, held, codes;
    int          failures, cmp_count, seed, n;
    cpr_divider_model model (.clk(clk), .reset(reset), .setting(setting), .codes(codes),
        .code_valid(code_valid));
    cpr_config_reader #(.TIMEOUT_CYCLES(TMO)) uut (.clk(clk), .reset(reset),
        .input_supply_pin(rails[3]), .high_bias_regulator_rail(rails[2]),
        .driver_supply_rail(rails[1]), .logic_supply_ok(rails[0]), .enable_pin(enable_pin),
        .boot_voltage_code_pin(codes[31:24]), .mode_address_code_pin(codes[23:16]),
        .fault_frequency_code_pin(codes[15:8]), .ramp_loop_code_pin(codes[7:0]),
        .code_valid(code_valid), .on_off_config(on_off_config), .operation_on(operation_on),
        .vout_cmd_write(vout_cmd_write), .vout_cmd_value(vout_cmd_value), .cmd_read(cmd_read),
        .cmd_code(cmd_code), .read_data(read_data), .read_ack(read_ack),
        .device_enabled(device_enabled), .bus_accessible(bus_accessible),
        .boot_voltage_code(boot_code), .output_off(output_off), .drive_oe_n(drive_oe_n),
        .pulse_skipping_mode(pskip), .thermistor_compensation(therm),
        .bus_address_select(addr), .ultrasonic_light_load_enable(ultra),
        .fault_retry_mode(retry), .frequency_select(freq), .amp_gain_select(gain),
        .ramp_rate_select(rate), .loop_ramp_resistor_select(rres),
        .gain_multiplier_select(mult));
    // ----------------------------------------------------------
    // expectations, checks and bus tasks
    // ----------------------------------------------------------
    function automatic logic [7:0] exp_read(input logic [7:0] c);
        return (c inside {[8'hdc:8'hdf]}) ? held[8 * (8'hdf - c) +: 8] : 8'h00;
    endfunction : exp_read
    function automatic logic exp_on(input logic [1:0] cfg, input logic op);
        return enable_pin && (cfg == 2'h0 || cfg == 2'h2 || op);
    endfunction : exp_on
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    // holds the strobe high between back-to-back reads; caller releases it
    task automatic bus_read(input logic [7:0] c);
        cmd_read = 1'b1;
        cmd_code = c;
        @(negedge clk);
        check({read_ack, read_data}, {c inside {[8'hdc:8'hdf]}, exp_read(c)});
    endtask : bus_read
    task automatic power_up(input logic [1:0] cfg, input logic op);
        reset = 1'b1;
        on_off_config = cfg;
        operation_on = op;
        held = setting;
        repeat (12) @(negedge clk);
        reset = 1'b0;
        n = 0;
        while (bus_accessible !== 1'b1 && n < 200) begin
            @(negedge clk);
            n++;
        end
        check(32'(n > TMO && n < TMO + 8), 32'h1);
        // the enable decision lands one edge after the bus becomes accessible
        @(negedge clk);
    endtask : power_up
    task automatic print_verdict;
        $display("comparisons %0d failures %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : print_verdict
    // ----------------------------------------------------------
    // clock, watchdog and main sequence
    // ----------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    initial begin
        #50us;
        failures++;
        print_verdict();
    end
    initial begin
        {failures, cmp_count, seed} = {32'd0, 32'd0, 32'd76095};
        {reset, enable_pin, operation_on, vout_cmd_write, cmd_read} = 5'b11000;
        {rails, on_off_config, vout_cmd_value, cmd_code, setting} = '0;
        rails = 4'hf;
        @(negedge clk);
        // all-zero and all-one codes bracket the random ones
        for (int k = 0; k < 4; k++) begin
            setting = (k == 0) ? 32'h0 : (k == 3) ? 32'hffffffff : $random(seed);
            power_up(2'(k), 1'b0);
            check(device_enabled, exp_on(2'(k), 1'b0));
            if (k[0]) begin
                v2 = (k == 3) ? 8'h00 : 8'($random(seed)) | 8'h01;
                vout_cmd_write = 1'b1;
                vout_cmd_value = 8'($random(seed));
                @(negedge clk);
                vout_cmd_value = v2;
                @(negedge clk);
                vout_cmd_write = 1'b0;
                repeat (2) @(negedge clk);
                check(boot_code, v2);
                operation_on = 1'b1;
            end else begin
                v2 = held[31:24];
            end
            repeat (2) @(negedge clk);
            check(device_enabled, 1'b1);
            check({boot_code, output_off, drive_oe_n}, {v2, v2 == 8'h00, v2 == 8'h00});
            vout_cmd_write = 1'b1;
            vout_cmd_value = ~v2;
            @(negedge clk);
            vout_cmd_write = 1'b0;
            repeat (3) @(negedge clk);
            check(boot_code, v2);
            for (int c = 8'hdb; c <= 8'he0; c++) bus_read(8'(c));
            cmd_read = 1'b0;
            check({pskip, therm, addr, ultra, retry, freq, gain, rate, rres, mult},
                {held[23:8], held[7:2]});
            enable_pin = 1'b0;
            @(negedge clk);
            check(device_enabled, 1'b0);
            enable_pin = 1'b1;
            rails[$unsigned($random(seed)) % 4] = 1'b0;
            setting = ~setting;
            repeat (2) @(negedge clk);
            check(device_enabled, 1'b0);
            rails = 4'hf;
            repeat (TMO + 8) @(negedge clk);
            for (int c = 8'hdc; c <= 8'hdf; c++) bus_read(8'(c));
            cmd_read = 1'b0;
            @(negedge clk);
        end
        print_verdict();
    end
endmodule : testbench
bind cpr_config_reader cpr_config_reader_assertions #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) chk (.*);
`default_nettype wire
